// >>> hw/osc_pkg.sv
package osc_pkg;

    // array geometry
    localparam int SECTOR_COUNT = 4;
    localparam int ROW_COUNT    = 512;
    localparam int MAIN_ROWS    = SECTOR_COUNT * ROW_COUNT;
    localparam int RED_ROWS     = 8;
    localparam int WORD_W       = 32;
    localparam int ADDR_W       = 16;
    localparam int CTRL_W       = 16;
    localparam int IDX_W        = 12;

    // programming port resource numbers
    localparam logic [23:0] RES_ID_ADDR = 24'h100200;
    localparam logic [23:0] RES_ID_DATA = 24'h200100;
    localparam logic [23:0] RES_ID_CTRL = 24'h100300;

    // register port map
    localparam int          BUS_AW       = 8;
    localparam logic [7:0]  REG_OTP_ADDR = 8'h00;
    localparam logic [7:0]  REG_OTP_DATA = 8'h04;
    localparam logic [7:0]  REG_OTP_CTRL = 8'h08;
    localparam logic [7:0]  REG_SECURITY = 8'h0C;
    localparam logic [7:0]  REG_STATUS   = 8'h10;
    localparam logic [7:0]  REG_USERCODE = 8'h14;

    // reset values
    localparam logic [15:0] OTP_ADDR_RST = 16'h0000;
    localparam logic [31:0] OTP_DATA_RST = 32'h0000_0000;
    localparam logic [15:0] OTP_CTRL_RST = 16'h0000;
    localparam logic [31:0] SEC_RST      = 32'h0000_0000;

    // security feature bit positions
    localparam int SEC_JTAG_OFF = 0;
    localparam int SEC_LINK_OFF = 1;
    localparam int SEC_BOOT_OTP = 5;
    localparam int SEC_RED_EN   = 7;
    localparam int SEC_LOCK0    = 8;
    localparam int SEC_MASTER   = 12;
    localparam int SEC_JTAG_OTP = 13;
    localparam int SEC_SW_LO    = 15;
    localparam int SEC_UID_LO   = 22;
    localparam logic [31:0] SEC_USED_MASK = 32'hFFFF_BFA3;

    // control and status fields
    localparam int CTRL_PROG   = 0;
    localparam int CTRL_READ   = 1;
    localparam int CTRL_SECREG = 2;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_DONE   = 1;
    localparam int STAT_DENIED = 2;
    localparam int STAT_BOOTED = 3;

    // address layout
    localparam int ADDR_RED_BIT = 11;

    typedef enum logic [2:0] {
        OSC_BOOT_SEC   = 3'b000,
        OSC_BOOT_LATCH = 3'b001,
        OSC_COPY       = 3'b011,
        OSC_IDLE       = 3'b010,
        OSC_OP_WAIT    = 3'b110
    } osc_fsm_t;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [31:0] wdata;
    } osc_jtag_req_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        sec;
        logic [11:0] idx;
        logic [31:0] wdata;
    } osc_arr_cmd_t;

    function automatic logic osc_addr_ok(input logic [15:0] a, input logic red_en);
        return (a[15:12] == 4'h0) &&
               (!a[ADDR_RED_BIT] || (red_en && (a[10:0] < 11'(RED_ROWS))));
    endfunction : osc_addr_ok

endpackage : osc_pkg

// >>> hw/osc_otp_array.sv
`timescale 1ns/100ps
`default_nettype none

module osc_otp_array #(
    parameter int DEPTH = osc_pkg::MAIN_ROWS + osc_pkg::RED_ROWS
) (
    // clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    // command
    input  wire osc_pkg::osc_arr_cmd_t cmd_i,
    // read data, one cycle after the read
    output logic [31:0]               rdata_o
);

    typedef struct packed {
        logic [31:0] rdata;
    } osc_arr_state_t;

    osc_arr_state_t cur;
    osc_arr_state_t next_cur;

    // four sectors of 512 words plus redundant rows
    // blank fuses read as zero; set at declaration so only the write process drives them
    logic [31:0] fuse_mem [DEPTH] = '{default: 32'h0000_0000};
    logic [31:0] fuse_sec         = 32'h0000_0000;

    always_comb begin
        next_cur = cur;
        if (cmd_i.rd) begin
            next_cur.rdata = cmd_i.sec ? fuse_sec : fuse_mem[cmd_i.idx];
        end
    end

    // fuses only ever gain ones, so a write merges into the old word
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
        if (cmd_i.wr && cmd_i.sec) begin
            fuse_sec <= fuse_sec | cmd_i.wdata;
        end else if (cmd_i.wr) begin
            fuse_mem[cmd_i.idx] <= fuse_mem[cmd_i.idx] | cmd_i.wdata;
        end
    end

    assign rdata_o = cur.rdata;

endmodule : osc_otp_array

`default_nettype wire

// >>> hw/osc_prog_guard.sv
`timescale 1ns/100ps
`default_nettype none

module osc_prog_guard (
    // effective security word
    input  wire logic [31:0] sec_i,
    // request
    input  wire logic [15:0] addr_i,
    input  wire logic        we_i,
    input  wire logic        to_sec_i,
    input  wire logic        from_jtag_i,
    // verdict
    output logic             allow_o
);

    logic       addr_ok;
    logic       sect_lock;
    logic       wr_ok;
    logic       jtag_ok;
    logic [1:0] sector;

    assign sector    = addr_i[10:9];
    assign addr_ok   = to_sec_i || osc_pkg::osc_addr_ok(addr_i, sec_i[osc_pkg::SEC_RED_EN]);
    // redundant rows follow only the master lock
    assign sect_lock = !to_sec_i && !addr_i[osc_pkg::ADDR_RED_BIT] &&
                       sec_i[osc_pkg::SEC_LOCK0 + int'(sector)];
    assign wr_ok     = !sec_i[osc_pkg::SEC_MASTER] && !sect_lock;
    assign jtag_ok   = !sec_i[osc_pkg::SEC_JTAG_OFF] && !sec_i[osc_pkg::SEC_JTAG_OTP];
    assign allow_o   = addr_ok && (!we_i || wr_ok) && (!from_jtag_i || jtag_ok);

endmodule : osc_prog_guard

`default_nettype wire

// >>> hw/osc_top.sv
// Notes on behaviour
// - array holds four sectors of 512 rows, each row a 32-bit word
// - security word is fetched from fuses at reset before features apply
// - after that all main rows are copied out to SRAM, the last word in the cycle the cpu starts running
// - programming address goes through a 16-bit port, resource 0x100200
// - programming data goes through a 32-bit port, resource 0x200100
// - programming control goes through a 16-bit port, resource 0x100300
// - bit 0 shuts the JTAG side off completely
// - bit 1 refuses other tiles access over the switch
// - bit 5 skips the boot ROM and boots from fuse row 0
// - bit 7 opens the redundant rows
// - bits 8 to 11 lock programming of sectors 0 to 3, reads unaffected
// - bit 12 refuses every programming, security word included
// - bit 13 blocks JTAG reads and writes of the fuses
// - bits 21 to 15 are a software readable user field
// - bits 31 to 22 extend the JTAG user identification
// - usercode is returned to JTAG when usercode is selected and JTAG is enabled, zero otherwise
// - usercode user field is tile 0 security bits 31 to 22, zero when blank
`timescale 1ns/100ps
`default_nettype none

module osc_top #(
    parameter int          TILE0       = 1,
    parameter logic [17:0] SILICON_REV = 18'h00001  // arbitrary value
) (
    // clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_n_i,
    // register port
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [31:0]           reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic [31:0]                reg_rdata_o,
    // jtag side
    input  wire logic                  jtag_req_i,
    input  wire osc_pkg::osc_jtag_req_t jtag_cmd_i,
    input  wire logic                  jtag_usercode_sel_i,
    output logic                       jtag_ack_o,
    output logic                       jtag_denied_o,
    output logic [31:0]                jtag_rdata_o,
    output logic [31:0]                jtag_usercode_o,
    // security controls
    input  wire logic [9:0]            tile0_user_id_i,
    output logic                       jtag_enable_o,
    output logic                       link_access_en_o,
    output logic                       boot_from_otp_o,
    output logic                       cpu_run_o,
    // boot copy to sram
    output logic                       sram_we_o,
    output logic [10:0]                sram_addr_o,
    output logic [31:0]                sram_wdata_o
);

    typedef struct packed {
        osc_pkg::osc_fsm_t fsm;
        logic [31:0]       sec;
        logic              booted;
        logic [15:0]       otp_addr;
        logic [31:0]       otp_data;
        logic [15:0]       ctrl;
        logic              pend;
        logic              done;
        logic              denied;
        logic [10:0]       copy_idx;
        logic              copy_pend;
        logic [10:0]       copy_addr;
        logic              op_jtag;
        logic [31:0]       rdata;
        logic              jtag_ack;
        logic              jtag_den;
        logic [31:0]       jtag_rdata;
        logic [31:0]       jtag_uc;
        logic [31:0]       usercode;
    } osc_top_state_t;

    osc_top_state_t        cur;
    osc_top_state_t        next_cur;
    osc_pkg::osc_arr_cmd_t arr_cmd;
    logic [31:0]           arr_rdata;
    logic                  sw_allow;
    logic                  jtag_allow;
    logic [9:0]            uid_src;
    logic                  sw_prog;
    logic                  sw_read;

    assign sw_prog = cur.ctrl[osc_pkg::CTRL_PROG];
    assign sw_read = cur.ctrl[osc_pkg::CTRL_READ];
    assign uid_src = (TILE0 != 0) ? cur.sec[31:osc_pkg::SEC_UID_LO] : tile0_user_id_i;

    osc_otp_array u_array (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .cmd_i     (arr_cmd),
        .rdata_o   (arr_rdata)
    );

    osc_prog_guard u_sw_guard (
        .sec_i       (cur.sec),
        .addr_i      (cur.otp_addr),
        .we_i        (sw_prog),
        .to_sec_i    (cur.ctrl[osc_pkg::CTRL_SECREG]),
        .from_jtag_i (1'b0),
        .allow_o     (sw_allow)
    );

    osc_prog_guard u_jtag_guard (
        .sec_i       (cur.sec),
        .addr_i      (jtag_cmd_i.addr),
        .we_i        (jtag_cmd_i.we),
        .to_sec_i    (1'b0),
        .from_jtag_i (1'b1),
        .allow_o     (jtag_allow)
    );

    always_comb begin
        next_cur           = cur;
        arr_cmd            = '0;
        next_cur.rdata     = 32'h0000_0000;
        next_cur.jtag_ack  = 1'b0;
        next_cur.jtag_den  = 1'b0;
        next_cur.copy_pend = 1'b0;
        next_cur.usercode  = {uid_src, 4'h0, SILICON_REV};
        next_cur.jtag_uc   = (jtag_usercode_sel_i && jtag_enable_o) ? cur.usercode : 32'h0000_0000;

        // port writes are held off while a command is outstanding
        if (reg_wr_i && !cur.pend) begin
            case (reg_addr_i)
                osc_pkg::REG_OTP_ADDR: next_cur.otp_addr = reg_wdata_i[15:0];
                osc_pkg::REG_OTP_DATA: next_cur.otp_data = reg_wdata_i;
                osc_pkg::REG_OTP_CTRL: begin
                    next_cur.ctrl   = reg_wdata_i[15:0];
                    next_cur.pend   = 1'b1;
                    next_cur.done   = 1'b0;
                    next_cur.denied = 1'b0;
                end
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                osc_pkg::REG_OTP_ADDR: next_cur.rdata = {16'h0000, cur.otp_addr};
                osc_pkg::REG_OTP_DATA: next_cur.rdata = cur.otp_data;
                osc_pkg::REG_OTP_CTRL: next_cur.rdata = {16'h0000, cur.ctrl};
                osc_pkg::REG_SECURITY: next_cur.rdata = cur.sec;
                osc_pkg::REG_STATUS:   next_cur.rdata = {28'h0000000, cur.booted, cur.denied,
                                                         cur.done, cur.pend};
                osc_pkg::REG_USERCODE: next_cur.rdata = cur.usercode;
                default:               next_cur.rdata = 32'h0000_0000;
            endcase
        end

        case (cur.fsm)
            osc_pkg::OSC_BOOT_SEC: begin
                arr_cmd.rd   = 1'b1;
                arr_cmd.sec  = 1'b1;
                next_cur.fsm = osc_pkg::OSC_BOOT_LATCH;
            end
            osc_pkg::OSC_BOOT_LATCH: begin
                next_cur.sec      = arr_rdata & osc_pkg::SEC_USED_MASK;
                next_cur.copy_idx = 11'h000;
                next_cur.fsm      = osc_pkg::OSC_COPY;
            end
            osc_pkg::OSC_COPY: begin
                arr_cmd.rd         = 1'b1;
                arr_cmd.idx        = {1'b0, cur.copy_idx};
                next_cur.copy_pend = 1'b1;
                next_cur.copy_addr = cur.copy_idx;
                next_cur.copy_idx  = cur.copy_idx + 11'h001;
                if (cur.copy_idx == 11'(osc_pkg::MAIN_ROWS - 1)) begin
                    next_cur.booted = 1'b1;
                    next_cur.fsm    = osc_pkg::OSC_IDLE;
                end
            end
            osc_pkg::OSC_IDLE: begin
                if (cur.pend) begin
                    // software first; a jtag request simply waits
                    arr_cmd.sec   = cur.ctrl[osc_pkg::CTRL_SECREG];
                    arr_cmd.idx   = cur.otp_addr[11:0];
                    arr_cmd.wdata = cur.otp_data;
                    if ((sw_prog == sw_read) || !sw_allow) begin
                        next_cur.denied = 1'b1;
                        next_cur.done   = 1'b1;
                        next_cur.pend   = 1'b0;
                    end else if (sw_prog) begin
                        arr_cmd.wr    = 1'b1;
                        next_cur.done = 1'b1;
                        next_cur.pend = 1'b0;
                    end else begin
                        arr_cmd.rd       = 1'b1;
                        next_cur.op_jtag = 1'b0;
                        next_cur.fsm     = osc_pkg::OSC_OP_WAIT;
                    end
                end else if (jtag_req_i && !cur.jtag_ack) begin
                    arr_cmd.idx   = jtag_cmd_i.addr[11:0];
                    arr_cmd.wdata = jtag_cmd_i.wdata;
                    if (!jtag_allow) begin
                        next_cur.jtag_ack = 1'b1;
                        next_cur.jtag_den = 1'b1;
                    end else if (jtag_cmd_i.we) begin
                        arr_cmd.wr        = 1'b1;
                        next_cur.jtag_ack = 1'b1;
                    end else begin
                        arr_cmd.rd       = 1'b1;
                        next_cur.op_jtag = 1'b1;
                        next_cur.fsm     = osc_pkg::OSC_OP_WAIT;
                    end
                end
            end
            osc_pkg::OSC_OP_WAIT: begin
                if (cur.op_jtag) begin
                    next_cur.jtag_rdata = arr_rdata;
                    next_cur.jtag_ack   = 1'b1;
                end else begin
                    next_cur.otp_data = arr_rdata;
                    next_cur.done     = 1'b1;
                    next_cur.pend     = 1'b0;
                end
                next_cur.fsm = osc_pkg::OSC_IDLE;
            end
            default: next_cur.fsm = osc_pkg::OSC_BOOT_SEC;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cur          <= '0;
            cur.fsm      <= osc_pkg::OSC_BOOT_SEC;
            cur.sec      <= osc_pkg::SEC_RST;
            cur.otp_addr <= osc_pkg::OTP_ADDR_RST;
            cur.otp_data <= osc_pkg::OTP_DATA_RST;
            cur.ctrl     <= osc_pkg::OTP_CTRL_RST;
        end else begin
            cur <= next_cur;
        end
    end

    // everything stays shut until the last main row is copied out, after the security word is in place
    assign jtag_enable_o    = cur.booted && !cur.sec[osc_pkg::SEC_JTAG_OFF];
    assign link_access_en_o = cur.booted && !cur.sec[osc_pkg::SEC_LINK_OFF];
    assign boot_from_otp_o  = cur.booted && cur.sec[osc_pkg::SEC_BOOT_OTP];
    assign cpu_run_o        = cur.booted;
    assign reg_rdata_o      = cur.rdata;
    assign jtag_ack_o       = cur.jtag_ack;
    assign jtag_denied_o    = cur.jtag_den;
    assign jtag_rdata_o     = cur.jtag_rdata;
    assign jtag_usercode_o  = cur.jtag_uc;
    assign sram_we_o        = cur.copy_pend;
    assign sram_addr_o      = cur.copy_addr;
    assign sram_wdata_o     = arr_rdata;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_early_shut:   assert property (!cur.booted |-> !jtag_enable_o && !link_access_en_o)
        else $error("feature open before security load");
    a_copy_order:   assert property (sram_we_o && $past(sram_we_o)
        |-> sram_addr_o == $past(sram_addr_o) + 11'h001)
        else $error("sram copy out of order");
    a_jtag_off:     assert property (cur.sec[0] && $past(cur.sec[0])
        |-> !jtag_enable_o && jtag_usercode_o == 32'h0000_0000)
        else $error("jtag alive while disabled");
    a_link_off:     assert property (cur.sec[1] |-> !link_access_en_o)
        else $error("link access while disabled");
    a_secure_boot:  assert property (cur.booted |-> boot_from_otp_o == cur.sec[5])
        else $error("boot source wrong");
    a_red_gate:     assert property ((arr_cmd.rd || arr_cmd.wr) && !arr_cmd.sec && arr_cmd.idx[11]
        && cur.booted |-> cur.sec[7])
        else $error("redundant row used while closed");
    a_sector_lock:  assert property (arr_cmd.wr && !arr_cmd.sec && !arr_cmd.idx[11]
        |-> !cur.sec[osc_pkg::SEC_LOCK0 + int'(arr_cmd.idx[10:9])])
        else $error("locked sector programmed");
    a_master_lock:  assert property (arr_cmd.wr |-> !cur.sec[12])
        else $error("programming under master lock");
    a_jtag_otp:     assert property (cur.fsm == osc_pkg::OSC_IDLE && !cur.pend && jtag_req_i
        && !cur.jtag_ack && cur.sec[13] |=> jtag_ack_o && jtag_denied_o)
        else $error("jtag fuse access not refused");
    a_sec_read:     assert property (reg_rd_i && reg_addr_i == osc_pkg::REG_SECURITY
        |=> reg_rdata_o == $past(cur.sec))
        else $error("security read wrong");
    a_uc_select:    assert property (jtag_usercode_sel_i && jtag_enable_o
        |=> jtag_usercode_o == $past(cur.usercode))
        else $error("usercode not returned");
    a_uid_field:    assert property (cur.booted |=> cur.usercode[31:22] == $past(uid_src))
        else $error("user id field wrong");
    a_refused_keep: assert property (cur.fsm == osc_pkg::OSC_IDLE && cur.pend && !sw_allow
        |-> !arr_cmd.wr ##1 cur.denied && cur.done)
        else $error("refused programming touched fuses");
    a_unused_zero:  assert property ((cur.sec & ~osc_pkg::SEC_USED_MASK) == 32'h0000_0000)
        else $error("unassigned security bit set");

    c_booted:  cover property ($rose(cur.booted));
    c_sw_prog: cover property (arr_cmd.wr && !cur.op_jtag && cur.pend);
    c_denied:  cover property ($rose(cur.denied));
    c_jtag_rd: cover property (cur.fsm == osc_pkg::OSC_OP_WAIT && cur.op_jtag ##1 jtag_ack_o);

endmodule : osc_top

`default_nettype wire

// >>> sim/osc_jtag_host.sv
`timescale 1ns/100ps
`default_nettype none

// debug host on the jtag side; idle command lines show the inverse of the last value
module osc_jtag_host (
    // clock
    input  wire logic                   sys_clk_i,
    // request
    output logic                        req_o,
    output osc_pkg::osc_jtag_req_t      cmd_o,
    // answer
    input  wire logic                   ack_i,
    input  wire logic                   denied_i,
    input  wire logic [31:0]            rdata_i
);
    initial begin
        req_o = 1'b0;
        cmd_o = '0;
    end

    // request stands until ack is sampled high, bounded so a dead block cannot hang us
    task automatic xfer(input logic we, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic den);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        req_o <= 1'b1;
        cmd_o <= '{we: we, addr: a, wdata: d};
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 20);
        rd = rdata_i;
        // a timeout shows as unknown so the bench counts it
        den = (ack_i === 1'b1) ? denied_i : 1'bx;
        req_o <= 1'b0;
        cmd_o <= ~cmd_o;
    endtask : xfer
endmodule : osc_jtag_host

`default_nettype wire

// >>> sim/osc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module osc_top_tb;
    localparam logic [17:0] REV = 18'h00001;  // arbitrary value
    logic                   sys_clk_i = 1'b0;
    logic                   rst_n_i   = 1'b0;
    logic [7:0]             raddr     = '0;
    logic [31:0]            rwdata    = '0;
    logic                   rwr       = 1'b0;
    logic                   rrd       = 1'b0;
    logic                   usel      = 1'b0;
    logic [9:0]             uid_in    = '0;
    logic [31:0]            rrdata, jrdata, jucode, jucode1, swdata, st, rv;
    logic [31:0]            seed      = 32'd31905;
    logic [31:0]            sec_exp   = '0;
    logic [31:0]            sec_pend  = '0;
    logic                   jreq, jack, jden, jen, lnk, botp, run, swe, den;
    logic [10:0]            saddr;
    osc_pkg::osc_jtag_req_t jcmd;
    logic [31:0]            exp_mem [0:2047] = '{default: 32'h0};
    logic [31:0]            exp_red [0:7]    = '{default: 32'h0};
    int                     error_cnt = 0, n_checks = 0, copy_n = 0, copy_bad = 0;

    always #4 sys_clk_i = ~sys_clk_i;

    osc_top #(.TILE0(1), .SILICON_REV(REV)) uut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(raddr),
        .reg_wdata_i(rwdata), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rrdata),
        .jtag_req_i(jreq), .jtag_cmd_i(jcmd), .jtag_usercode_sel_i(usel),
        .jtag_ack_o(jack), .jtag_denied_o(jden), .jtag_rdata_o(jrdata),
        .jtag_usercode_o(jucode), .tile0_user_id_i(uid_in), .jtag_enable_o(jen),
        .link_access_en_o(lnk), .boot_from_otp_o(botp), .cpu_run_o(run),
        .sram_we_o(swe), .sram_addr_o(saddr), .sram_wdata_o(swdata));

    osc_jtag_host host (.sys_clk_i(sys_clk_i), .req_o(jreq), .cmd_o(jcmd),
        .ack_i(jack), .denied_i(jden), .rdata_i(jrdata));

    // a tile other than tile 0 takes its user field from the pin
    osc_top #(.TILE0(0), .SILICON_REV(REV)) uut1 (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(raddr),
        .reg_wdata_i(rwdata), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(),
        .jtag_req_i(jreq), .jtag_cmd_i(jcmd), .jtag_usercode_sel_i(usel),
        .jtag_ack_o(), .jtag_denied_o(), .jtag_rdata_o(),
        .jtag_usercode_o(jucode1), .tile0_user_id_i(uid_in), .jtag_enable_o(),
        .link_access_en_o(), .boot_from_otp_o(), .cpu_run_o(),
        .sram_we_o(), .sram_addr_o(), .sram_wdata_o());

    // every copied word must follow in order and match what was burnt
    always @(posedge sys_clk_i) if (swe === 1'b1) begin
        if (saddr !== copy_n[10:0] || swdata !== exp_mem[saddr]) copy_bad++;
        copy_n++;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // redundant rows obey only the master lock
    function automatic logic denies(input logic [15:0] a);
        if (sec_exp[12] || a[15:12] != 4'h0) return 1'b1;
        if (a[11]) return !(sec_exp[7] && a[10:0] < 11'd8);
        return sec_exp[8 + int'(a[10:9])];
    endfunction : denies

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        rwr <= 1'b1;
        raddr <= a;
        rwdata <= d;
        @(posedge sys_clk_i);
        rwr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        rrd <= 1'b1;
        raddr <= a;
        @(posedge sys_clk_i);
        rrd <= 1'b0;
        #1 d = rrdata;
    endtask : rd

    task automatic op(input logic [15:0] a, input logic [31:0] d, input logic [15:0] c);
        int n;
        n = 0;
        wr(osc_pkg::REG_OTP_ADDR, {16'h0, a});
        wr(osc_pkg::REG_OTP_DATA, d);
        wr(osc_pkg::REG_OTP_CTRL, {16'h0, c});
        do begin
            rd(osc_pkg::REG_STATUS, st);
            n++;
        end while (st[1] !== 1'b1 && st[2] !== 1'b1 && n < 40);
        chk("op done", 32'h1, {31'h0, st[1]});
    endtask : op

    task automatic rb(input logic [15:0] a);
        op(a, 32'h0, 16'h0002);
        rd(osc_pkg::REG_OTP_DATA, rv);
        chk("row data", a[11] ? exp_red[a[2:0]] : exp_mem[a[10:0]], rv);
    endtask : rb

    task automatic prog(input logic [15:0] a, input logic [31:0] d);
        den = denies(a);
        op(a, d, 16'h0001);
        chk("prog refused", {31'h0, den}, {31'h0, st[2]});
        if (!den && a[11]) exp_red[a[2:0]] |= d;
        else if (!den) exp_mem[a[10:0]] |= d;
        if (a[15:12] == 4'h0 && (!a[11] || sec_exp[7])) rb(a);
    endtask : prog

    task automatic ucode();
        @(posedge sys_clk_i);
        usel <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        chk("jtag usercode", sec_exp[0] ? 32'h0 : {sec_exp[31:22], 4'h0, REV}, jucode);
        chk("tile usercode", sec_exp[0] ? 32'h0 : {uid_in, 4'h0, REV}, jucode1);
        usel <= 1'b0;
    endtask : ucode

    // fuse changes to the security word only show after a reset
    task automatic boot();
        int n;
        n = 0;
        copy_n = 0;
        copy_bad = 0;
        sec_exp = sec_pend;
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        chk("run in reset", 32'h0, {31'h0, run});
        rst_n_i <= 1'b1;
        while (run !== 1'b1 && n < 3000) begin
            @(posedge sys_clk_i);
            n++;
        end
        // one more edge so the monitor has counted the last copied word
        @(posedge sys_clk_i);
        chk("copy count", 32'd2048, 32'(copy_n));
        chk("copy data", 32'h0, 32'(copy_bad));
        rd(osc_pkg::REG_SECURITY, rv);
        chk("security", sec_exp, rv);
        chk("jtag on", {31'h0, !sec_exp[0]}, {31'h0, jen});
        chk("link on", {31'h0, !sec_exp[1]}, {31'h0, lnk});
        chk("otp boot", {31'h0, sec_exp[5]}, {31'h0, botp});
        rd(osc_pkg::REG_USERCODE, rv);
        chk("usercode", {sec_exp[31:22], 4'h0, REV}, rv);
    endtask : boot

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out

    initial begin
        #(8 * 20000);
        error_cnt++;
        close_out();
    end

    initial begin
        rv = rnd();
        uid_in <= rv[9:0];
        boot();
        rd(8'h40, rv);
        chk("unmapped", 32'h0, rv);
        prog(16'h0000, rnd());
        prog(16'h07FF, rnd());
        prog(16'h0800, rnd());
        prog(16'h1000, rnd());
        prog(16'h0200, rnd());
        repeat (6) begin
            rv = rnd();
            prog({5'h0, rv[10:0]}, rnd());
        end
        host.xfer(1'b0, 16'h0000, 32'h0, rv, den);
        chk("jtag read", exp_mem[0], rv);
        rv = rnd();
        host.xfer(1'b1, 16'h0010, rv, st, den);
        chk("jtag write", 32'h0, {31'h0, den});
        exp_mem[16] |= rv;
        rb(16'h0010);
        ucode();
        rv = rnd();
        op(16'h0000, (rv & 32'hFFFF_8000) | 32'h0000_0284, 16'h0005);
        sec_pend = sec_exp | (((rv & 32'hFFFF_8000) | 32'h0000_0284) & osc_pkg::SEC_USED_MASK);
        boot();
        ucode();
        prog(16'h0200, rnd());
        prog(16'h0803, rnd());
        prog(16'h0400, rnd());
        op(16'h0000, 32'h0000_3023, 16'h0005);
        sec_pend |= 32'h0000_3023;
        boot();
        prog(16'h0001, rnd());
        op(16'h0000, 32'h0000_0100, 16'h0005);
        chk("sec locked", 32'h1, {31'h0, st[2]});
        host.xfer(1'b0, 16'h0000, 32'h0, rv, den);
        chk("jtag refused", 32'h1, {31'h0, den});
        ucode();
        close_out();
    end
endmodule : osc_top_tb

`default_nettype wire
